// ===== logic/sd_pkg.sv
`default_nettype none
package sd_pkg;
  ////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 10; // system clock period
  localparam int TICK_PERIOD_NS = 50000; // nominal sampling tick, 50 us
  localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS; // clocks per nominal tick
  localparam int SERIAL_BPS = 19200; // nominal line rate the host is set to

  ////////////////////////////////////////////////////////////////////////
  // conversion
  localparam int CNT_W = 11; // counter and accumulator width, holds 1024
  localparam logic [10:0] SAMPLES_PER_RESULT = 11'h400; // 1024 samples per result
  localparam logic [7:0] THRESHOLD = 8'h37; // fixed compare threshold
  localparam logic [2:0] SENSED_CHANNEL = 3'h1; // converter channel that is sampled

  ////////////////////////////////////////////////////////////////////////
  // interval tick timer
  localparam int TIMER_W = 12; // timer counts up to its top and reloads
  localparam logic [11:0] TIMER_TOP = 12'hFFF; // overflow point
  localparam logic [7:0] RELOAD_HI_DEF = 8'h0E; // tick_reload_high reset value
  localparam logic [7:0] RELOAD_LO_DEF = 8'h70; // tick_reload_low reset value
  localparam logic [15:0] NOM_STEPS = 16'h1000 - {RELOAD_HI_DEF, RELOAD_LO_DEF}; // timer steps per nominal tick

  ////////////////////////////////////////////////////////////////////////
  // flag byte and port bits
  localparam int READY_BIT = 7; // result_ready_flag position
  localparam int MARKER_BIT = 6; // tick_marker_flag position
  localparam int TX_BIT = 6; // serial_tx_line in the first port
  localparam int FB_BIT = 4; // feedback output in the second port

  ////////////////////////////////////////////////////////////////////////
  // serial frame
  localparam logic [7:0] FRAME_SYNC = 8'hFF; // two sync bytes lead each frame
  localparam logic [1:0] LAST_BYTE = 2'h3; // four bytes per frame
  localparam logic [3:0] CHAR_BITS = 4'hA; // start, eight data, stop

  ////////////////////////////////////////////////////////////////////////
  // register map, byte addresses
  localparam logic [3:0] REG_CTRL = 4'h0; // bit0 run
  localparam logic [3:0] REG_RELOAD = 4'h4; // [15:8] high byte, [7:0] low byte
  localparam logic [3:0] REG_STATUS = 4'h8; // [7:0] flag byte, [26:16] result
  localparam logic [3:0] REG_COUNT = 4'hC; // [10:0] samples, [26:16] ones
  localparam int CTRL_RUN_BIT = 0; // run enable
  localparam int HI_LSB = 16; // lsb of the upper field in status and count

  ////////////////////////////////////////////////////////////////////////
  // state encodings
  typedef enum logic [1:0] {SP_IDLE = 2'b01, SP_WAIT = 2'b10} samp_state_t;
  typedef enum logic [2:0] {SQ_WAIT = 3'b001, SQ_LOAD = 3'b010, SQ_BUSY = 3'b100} seq_state_t;
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} tx_state_t;
endpackage
`default_nettype wire

// ===== logic/tx_link_if.sv
`default_nettype none
// carries one character request and the tick marker handshake
interface tx_link_if;
  logic [7:0] data; // character to send
  logic start; // request, taken while the transmitter is idle
  logic busy; // character in progress
  logic marker; // tick marker flag level
  logic marker_clr; // transmitter consumes the marker
  logic line; // serial line level

  modport seq (output data, output start, output marker, input busy, input marker_clr, input line);
  modport tx (input data, input start, input marker, output busy, output marker_clr, output line);
endinterface
`default_nettype wire

// ===== logic/serial_char_tx.sv
`default_nettype none
// sends one character, each level held for one tick marker
module serial_char_tx (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic ce,
  tx_link_if.tx lnk
);
  sd_pkg::tx_state_t state_r; // idle or sending
  logic [9:0] shreg_r; // levels still to put on the line, lsb first
  logic [3:0] left_r; // levels still to put out
  logic line_r; // line level

  ////////////////////////////////////////////////////////////////////////
  // handshake decode
  wire logic accept = (state_r == sd_pkg::TX_IDLE) && lnk.start; // new character taken
  wire logic bit_due = (state_r == sd_pkg::TX_SEND) && lnk.marker; // tick seen, next level
  assign lnk.marker_clr = accept || bit_due; // consume marker on alignment and each bit
  assign lnk.busy = (state_r == sd_pkg::TX_SEND);
  assign lnk.line = line_r;

  ////////////////////////////////////////////////////////////////////////
  // shift engine: taking a character clears the marker, then start, data lsb first, stop
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= sd_pkg::TX_IDLE;
      shreg_r <= 10'h000;
      left_r <= 4'h0;
      line_r <= 1'b1; // idle high
    end else if (ce) begin
      unique case (state_r)
        sd_pkg::TX_IDLE: begin
          if (accept) begin
            shreg_r <= {1'b1, lnk.data, 1'b0}; // stop, data, start
            left_r <= sd_pkg::CHAR_BITS;
            state_r <= sd_pkg::TX_SEND;
          end
        end
        sd_pkg::TX_SEND: begin
          if (bit_due) begin
            if (left_r == 4'h0) begin
              state_r <= sd_pkg::TX_IDLE; // stop level has stood one tick
            end else begin
              line_r <= shreg_r[0]; // one level per tick
              shreg_r <= {1'b0, shreg_r[9:1]};
              left_r <= left_r - 4'h1;
            end
          end
        end
        default: state_r <= sd_pkg::TX_IDLE;
      endcase
    end
  end
endmodule // serial_char_tx
`default_nettype wire

// ===== logic/sigma_delta_loop_decimator.sv
// Added by the designer: register access over Avalon-MM and the register offsets.
`default_nettype none
// Contract
// - one modulator sample per timer tick
// - 11-bit result every 1024 ticks
// - clear tick request, then sample x8 channel
// - compare sample with threshold 37 hex
// - below threshold: feedback high, count only
// - otherwise feedback low, count ones and samples
// - below 1024 samples the tick just ends
// - at 1024 latch result, flag ready, restart
// - counters cleared before the first conversion
// - sequencer waits ready, then sends result serially
// - serial line runs at the tick rate
// - tick period is a parameter
// - timer reload defaults to 0E hex, 70 hex
// - feedback port b4, serial port a6, high
// - flag byte: ready bit7, marker bit6
// - frame FF, FF, result high, result low
// - start low, eight data lsb first, stop high
// - tick sets marker; transmitter paces on it
module sigma_delta_loop_decimator #(
  parameter int TICK_CYCLES = sd_pkg::TICK_CYCLES_DEF // clocks per nominal tick
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] sample_data,
  input wire logic sample_valid,
  output logic sample_req,
  output logic gain_x8_en,
  output logic [2:0] channel_sel,
  output logic [7:0] port_a_out,
  output logic [7:0] port_b_out
);
  localparam int CNT_W = sd_pkg::CNT_W;
  localparam logic [15:0] TICK_CYC16 = 16'(TICK_CYCLES); // accumulator modulus

  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic run_r; // conversions enabled
  logic [15:0] reload_r; // tick_reload_high and tick_reload_low
  logic [15:0] frac_r; // fractional prescaler
  logic [11:0] timer_r; // interval_tick_timer count
  logic tick_pend_r; // pending tick request
  logic [7:0] flag_byte_r; // result_ready_flag and tick_marker_flag
  logic [CNT_W-1:0] samp_cnt_r; // sample counter
  logic [CNT_W-1:0] ones_r; // ones accumulator
  logic [CNT_W-1:0] result_r; // latched result buffer
  logic fb_r; // feedback level
  sd_pkg::samp_state_t samp_r; // sampler state
  sd_pkg::seq_state_t seq_r; // main sequencer state
  logic [1:0] byte_idx_r; // frame byte in flight
  logic waitreq_r; // bus wait
  logic [31:0] rdata_r; // bus read data
  logic sample_req_r;
  logic gain_r;
  logic [7:0] port_a_r;
  logic [7:0] port_b_r;
  tx_link_if lnk ();

  ////////////////////////////////////////////////////////////////////////
  // byte-lane merge, used for the reload register
  function automatic logic [7:0] lane(input logic [7:0] old, input logic [7:0] neu, input logic en);
    lane = en ? neu : old;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  wire logic bus_req = avs_read || avs_write;
  wire logic wr_go = avs_write && !waitreq_r; // write takes effect at the answering edge
  wire logic wr_ctrl = wr_go && (avs_address == sd_pkg::REG_CTRL);
  wire logic wr_reload = wr_go && (avs_address == sd_pkg::REG_RELOAD);
  wire logic [31:0] rd_mux =
    (avs_address == sd_pkg::REG_CTRL) ? {31'h0, run_r} :
    (avs_address == sd_pkg::REG_RELOAD) ? {16'h0, reload_r} :
    (avs_address == sd_pkg::REG_STATUS) ? {5'h0, result_r, 8'h0, flag_byte_r} :
    (avs_address == sd_pkg::REG_COUNT) ? {5'h0, ones_r, 5'h0, samp_cnt_r} :
    32'h0; // unmapped reads as zero

  ////////////////////////////////////////////////////////////////////////
  // tick timing decode
  // the prescaler adds the nominal step count every clock and
  // fires one timer step each time the tick modulus is passed
  wire logic [15:0] frac_sum = frac_r + sd_pkg::NOM_STEPS;
  wire logic step = run_r && (frac_sum >= TICK_CYC16); // one timer increment
  wire logic overflow = step && (timer_r == sd_pkg::TIMER_TOP);

  ////////////////////////////////////////////////////////////////////////
  // sampling decode
  wire logic take = (samp_r == sd_pkg::SP_WAIT) && sample_valid; // one step per sample
  wire logic below = sample_data < sd_pkg::THRESHOLD;
  wire logic [CNT_W-1:0] cnt_nxt = samp_cnt_r + 11'h001;
  wire logic [CNT_W-1:0] ones_nxt = below ? ones_r : ones_r + 11'h001;
  wire logic full = cnt_nxt == sd_pkg::SAMPLES_PER_RESULT;
  wire logic tick_start = (samp_r == sd_pkg::SP_IDLE) && tick_pend_r;

  ////////////////////////////////////////////////////////////////////////
  // frame and flag decode
  wire logic ready_clr = (seq_r == sd_pkg::SQ_WAIT) && flag_byte_r[sd_pkg::READY_BIT];
  wire logic ready_set = take && full;
  assign lnk.data = (byte_idx_r == 2'h2) ? {5'h0, result_r[10:8]} : // result high
                    (byte_idx_r == 2'h3) ? result_r[7:0] : sd_pkg::FRAME_SYNC;
  assign lnk.start = (seq_r == sd_pkg::SQ_LOAD);
  assign lnk.marker = flag_byte_r[sd_pkg::MARKER_BIT];

  ////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then answer for one cycle
  // read data are captured at the taking edge, so they stand with the answer
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      waitreq_r <= 1'b1;
      rdata_r <= 32'h0;
    end else if (ce) begin
      waitreq_r <= !(bus_req && waitreq_r); // low in the cycle after the request
      if (avs_read && waitreq_r) begin
        rdata_r <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_r <= 1'b1;
      reload_r <= {sd_pkg::RELOAD_HI_DEF, sd_pkg::RELOAD_LO_DEF};
    end else if (ce) begin
      if (wr_ctrl && avs_byteenable[0]) begin
        run_r <= avs_writedata[sd_pkg::CTRL_RUN_BIT];
      end
      if (wr_reload) begin
        reload_r <= {lane(reload_r[15:8], avs_writedata[15:8], avs_byteenable[1]),
                     lane(reload_r[7:0], avs_writedata[7:0], avs_byteenable[0])};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interval tick timer: fractional prescaler then reloading up-counter
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      frac_r <= 16'h0;
      timer_r <= {sd_pkg::RELOAD_HI_DEF[3:0], sd_pkg::RELOAD_LO_DEF};
      tick_pend_r <= 1'b0;
    end else if (ce) begin
      if (!run_r) begin
        frac_r <= 16'h0;
        timer_r <= reload_r[11:0];
      end else if (step) begin
        frac_r <= frac_sum - TICK_CYC16;
        timer_r <= overflow ? reload_r[11:0] : timer_r + 12'h001;
      end else begin
        frac_r <= frac_sum;
      end
      if (overflow) begin
        tick_pend_r <= 1'b1; // set wins over the clear below
      end else if (tick_start) begin
        tick_pend_r <= 1'b0; // request cleared first
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sampler: request one x8 sample per tick, then compare and count
  // a tick landing while a sample is awaited stays pending, one deep
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      samp_r <= sd_pkg::SP_IDLE;
      sample_req_r <= 1'b0;
      gain_r <= 1'b0;
      fb_r <= 1'b1; // initially high
      samp_cnt_r <= '0;
      ones_r <= '0;
      result_r <= '0;
    end else if (ce) begin
      sample_req_r <= 1'b0;
      unique case (samp_r)
        sd_pkg::SP_IDLE: begin
          if (tick_start) begin
            sample_req_r <= 1'b1;
            gain_r <= 1'b1; // x8 stage on for the sample
            samp_r <= sd_pkg::SP_WAIT;
          end
        end
        sd_pkg::SP_WAIT: begin
          if (take) begin
            gain_r <= 1'b0;
            fb_r <= below; // high below threshold, else low
            samp_r <= sd_pkg::SP_IDLE;
            if (full) begin
              result_r <= ones_nxt; // latch and restart
              samp_cnt_r <= '0;
              ones_r <= '0;
            end else begin
              samp_cnt_r <= cnt_nxt;
              ones_r <= ones_nxt;
            end
          end
        end
        default: samp_r <= sd_pkg::SP_IDLE;
      endcase
      if (!run_r) begin
        samp_cnt_r <= '0; // stopped: next conversion starts clean
        ones_r <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flag byte: hardware set wins over clear
  // the marker is consumed by the transmitter once per line level
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_byte_r <= 8'h00;
    end else if (ce) begin
      if (ready_set) begin
        flag_byte_r[sd_pkg::READY_BIT] <= 1'b1;
      end else if (ready_clr) begin
        flag_byte_r[sd_pkg::READY_BIT] <= 1'b0;
      end
      if (tick_start) begin
        flag_byte_r[sd_pkg::MARKER_BIT] <= 1'b1; // every tick
      end else if (lnk.marker_clr) begin
        flag_byte_r[sd_pkg::MARKER_BIT] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // main sequencer: wait for a result, then send the four-byte frame
  // ready clears as the frame starts, so a later result queues behind it
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      seq_r <= sd_pkg::SQ_WAIT;
      byte_idx_r <= 2'h0;
    end else if (ce) begin
      unique case (seq_r)
        sd_pkg::SQ_WAIT: begin
          if (ready_clr) begin
            byte_idx_r <= 2'h0;
            seq_r <= sd_pkg::SQ_LOAD;
          end
        end
        sd_pkg::SQ_LOAD: begin
          if (!lnk.busy) begin
            seq_r <= sd_pkg::SQ_BUSY; // transmitter takes the byte now
          end
        end
        sd_pkg::SQ_BUSY: begin
          if (!lnk.busy) begin
            byte_idx_r <= byte_idx_r + 2'h1;
            seq_r <= (byte_idx_r == sd_pkg::LAST_BYTE) ? sd_pkg::SQ_WAIT : sd_pkg::SQ_LOAD;
          end
        end
        default: seq_r <= sd_pkg::SQ_WAIT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // port images
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      port_a_r <= 8'h40; // serial line high
      port_b_r <= 8'h10; // feedback high
    end else if (ce) begin
      port_a_r <= 8'h00;
      port_a_r[sd_pkg::TX_BIT] <= lnk.line;
      port_b_r <= 8'h00;
      port_b_r[sd_pkg::FB_BIT] <= fb_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // character transmitter, paced by the tick marker
  // so the line rate follows the tick rate
  serial_char_tx u_tx (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .lnk(lnk.tx)
  );

  ////////////////////////////////////////////////////////////////////////
  // top outputs; all but the fixed channel come from registers
  assign avs_readdata = rdata_r;
  assign avs_waitrequest = waitreq_r;
  assign sample_req = sample_req_r;
  assign gain_x8_en = gain_r;
  assign channel_sel = sd_pkg::SENSED_CHANNEL;
  assign port_a_out = port_a_r;
  assign port_b_out = port_b_r;
endmodule // sigma_delta_loop_decimator
`default_nettype wire

// ===== sim/sd_loop_assertions.sv
`default_nettype none
// checks the loop decimator at its top ports
module sd_loop_assertions #(
  parameter int TICK_CYCLES = 5000 // clocks per tick, handed on by the bind
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [7:0] sample_data,
  input wire logic sample_valid,
  input wire logic sample_req,
  input wire logic gain_x8_en,
  input wire logic [2:0] channel_sel,
  input wire logic [7:0] port_a_out,
  input wire logic [7:0] port_b_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // a sample is taken while one is awaited
  wire take = gain_x8_en && sample_valid;
  ////////////////////////////////////////////////////////////////////////
  a_req_pulse: assert property (sample_req |=> !sample_req)
    else $error("sample request longer than one cycle");
  a_gain_on_req: assert property (sample_req |-> gain_x8_en)
    else $error("gain stage off at sample request");
  a_gain_holds: assert property (gain_x8_en && !sample_valid |=> gain_x8_en)
    else $error("gain stage dropped before the sample");
  a_gain_drops: assert property (take |=> !gain_x8_en)
    else $error("gain stage still on after the sample");
  a_chan_fixed: assert property (channel_sel == sd_pkg::SENSED_CHANNEL)
    else $error("wrong channel selected");
  a_fb_low: assert property (take && sample_data < sd_pkg::THRESHOLD |-> ##2 port_b_out[4])
    else $error("feedback not high after low sample");
  a_fb_high: assert property (take && sample_data >= sd_pkg::THRESHOLD |-> ##2 !port_b_out[4])
    else $error("feedback not low after high sample");
  a_fb_cause: assert property (port_b_out != $past(port_b_out) |-> $past(take, 2))
    else $error("feedback moved without a sample");
  a_spare_bits: assert property ((port_a_out & 8'hBF) == 8'h00 && (port_b_out & 8'hEF) == 8'h00)
    else $error("unused port bit set");
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest && ce |=> !avs_waitrequest)
    else $error("bus answer not after one wait cycle");
endmodule // sd_loop_assertions
`default_nettype wire

// ===== sim/sd_far_side.sv
`default_nettype none
// converter that answers sample requests, and the host serial receiver
module sd_far_side #(
  parameter int BIT_CYCLES = 20 // clocks per serial bit
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic sample_req,
  input wire logic [3:0] dly,
  input wire logic [7:0] level,
  input wire logic line,
  output logic [7:0] sample_data,
  output logic sample_valid,
  output logic [7:0] rx_byte,
  output logic rx_stb
);
  logic busy_r; // conversion in progress
  logic [3:0] wait_r; // cycles left in it
  logic [7:0] shift_r; // received bits
  logic prev_r; // line one clock ago
  int cnt; // clocks to the next bit centre
  int nb; // bit position, 0 when idle
  // converter: answers after dly cycles, data toggles when not valid
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_r <= 1'b0;
      sample_valid <= 1'b0;
      sample_data <= 8'h00;
    end else begin
      sample_valid <= 1'b0;
      sample_data <= ~sample_data;
      if (sample_req) begin
        busy_r <= 1'b1;
        wait_r <= dly;
      end else if (busy_r && wait_r == 4'h0) begin
        busy_r <= 1'b0;
        sample_valid <= 1'b1;
        sample_data <= level;
      end else if (busy_r) begin
        wait_r <= wait_r - 4'h1;
      end
    end
  end
  // receiver: start edge, then samples at bit centres, lsb first
  always @(posedge sys_clk) begin
    rx_stb <= 1'b0;
    prev_r <= line;
    if (sys_rst) begin
      nb <= 0;
      prev_r <= 1'b1;
    end else if (nb == 0) begin
      if (prev_r && !line) begin
        nb <= 1;
        cnt <= BIT_CYCLES / 2;
      end
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else begin
      cnt <= BIT_CYCLES;
      nb <= (nb == 10) ? 0 : nb + 1;
      if (nb >= 2 && nb <= 9) shift_r <= {line, shift_r[7:1]};
      // only a high stop bit delivers the byte
      if (nb == 10) rx_stb <= line;
      rx_byte <= shift_r;
    end
  end
endmodule // sd_far_side
`default_nettype wire

// ===== sim/test_sigma_delta_loop_decimator.sv
`default_nettype none
module test_sigma_delta_loop_decimator;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICKS = 500; // short prescaler modulus
  localparam int BITC = 20; // clocks per tick once reload is 0FF0
  logic sys_clk, sys_rst, ce, avs_read, avs_write, avs_waitrequest, sample_valid, sample_req, gain_x8_en;
  logic [3:0] avs_address, avs_byteenable, dly;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0] sample_data, port_a_out, port_b_out, level, rx_byte;
  logic [2:0] channel_sel;
  logic [10:0] m_cnt, m_ones, r, exp_q[$];
  logic [7:0] rx_q[$];
  logic [7:0] corner[4] = '{8'h37, 8'h38, 8'h00, 8'hFF};
  logic rx_stb, chk_d1, chk_d2, fb_d1, fb_d2;
  int fails, check_count, idx, cyc, t_res[$];
  sigma_delta_loop_decimator #(.TICK_CYCLES(TICKS)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sample_data(sample_data), .sample_valid(sample_valid), .sample_req(sample_req), .gain_x8_en(gain_x8_en),
    .channel_sel(channel_sel), .port_a_out(port_a_out), .port_b_out(port_b_out));
  sd_far_side #(.BIT_CYCLES(BITC)) far (.sys_clk(sys_clk), .sys_rst(sys_rst), .sample_req(sample_req),
    .dly(dly), .level(level), .line(port_a_out[6]), .sample_data(sample_data), .sample_valid(sample_valid),
    .rx_byte(rx_byte), .rx_stb(rx_stb));
  ////////////////////////////////////////////////////////////////////////
  // expectations and comparisons
  function automatic logic is_one(input logic [7:0] s);
    return s >= sd_pkg::THRESHOLD;
  endfunction
  function automatic logic [7:0] frame_byte(input logic [10:0] v, input int i);
    if (i < 2) return sd_pkg::FRAME_SYNC;
    return (i == 2) ? {5'h0, v[10:8]} : v[7:0];
  endfunction
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  // one bus access, held until waitrequest is seen low
  task automatic bus_req(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // sample monitor: feedback pipeline, result model, next sample from the four corners, then random
  always @(posedge sys_clk) begin
    cyc++;
    chk_d2 <= chk_d1;
    fb_d2 <= fb_d1;
    chk_d1 <= 1'b0;
    if (chk_d2) chk_bit(port_b_out[4], fb_d2, "feedback");
    if (rx_stb) rx_q.push_back(rx_byte);
    if (!sys_rst && ce && gain_x8_en && sample_valid) begin
      chk_d1 <= 1'b1;
      fb_d1 <= !is_one(sample_data);
      m_ones = m_ones + {10'h0, is_one(sample_data)};
      m_cnt = m_cnt + 11'h001;
      level <= (idx < 4) ? corner[idx] : 8'($urandom);
      dly <= 4'($urandom_range(7, 0));
      idx++;
      if (m_cnt == sd_pkg::SAMPLES_PER_RESULT) begin
        exp_q.push_back(m_ones);
        t_res.push_back(cyc);
        m_cnt = 11'h000;
        m_ones = 11'h000;
      end
    end
  end
  // watchdog
  initial begin
    repeat (90000) @(posedge sys_clk);
    fails++;
    stop_test();
  end
  // main sequence
  initial begin
    {sys_rst, ce, avs_read, avs_write, chk_d1, chk_d2} = 6'b110000;
    {avs_address, avs_byteenable, avs_writedata} = {4'h0, 4'hF, 32'h0};
    {level, dly, m_cnt, m_ones} = {8'h36, 4'h2, 22'h0};
    void'($urandom(32'hC8084499));
    repeat (6) @(posedge sys_clk);
    chk_val({24'h0, port_a_out}, 32'h40, "port a reset");
    chk_val({24'h0, port_b_out}, 32'h10, "port b reset");
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    bus_req(1'b0, sd_pkg::REG_RELOAD, 32'h0);
    chk_val(rd, 32'h0E70, "reload reset");
    bus_req(1'b0, sd_pkg::REG_COUNT, 32'h0);
    chk_val(rd, 32'h0, "counters reset");
    bus_req(1'b0, sd_pkg::REG_STATUS, 32'h0);
    chk_val(rd, 32'h0, "status reset");
    bus_req(1'b0, 4'h2, 32'h0);
    chk_val(rd, 32'h0, "unmapped read");
    bus_req(1'b1, sd_pkg::REG_RELOAD, 32'h0FF0);
    bus_req(1'b1, 4'h3, 32'hFFFFFFFF);
    bus_req(1'b0, sd_pkg::REG_RELOAD, 32'h0);
    chk_val(rd, 32'h0FF0, "reload written");
    repeat (2) begin
      while (rx_q.size() < 4) @(posedge sys_clk);
      r = exp_q.pop_front();
      for (int i = 0; i < 4; i++) chk_val({24'h0, rx_q.pop_front()}, {24'h0, frame_byte(r, i)}, "frame");
      bus_req(1'b0, sd_pkg::REG_STATUS, 32'h0);
      chk_val(rd & 32'h07FF0080, {5'h0, r, 16'h0}, "status result");
    end
    bus_req(1'b1, sd_pkg::REG_STATUS, 32'h0);
    bus_req(1'b0, sd_pkg::REG_STATUS, 32'h0);
    chk_val(rd & 32'h07FF0000, {5'h0, r, 16'h0}, "status write ignored");
    // clock enable low across a tick: no sample may be taken while frozen
    while (!(gain_x8_en && sample_valid)) @(posedge sys_clk);
    repeat (3) @(posedge sys_clk);
    ce <= 1'b0;
    repeat (40) @(posedge sys_clk);
    ce <= 1'b1;
    bus_req(1'b0, sd_pkg::REG_COUNT, 32'h0);
    chk_val(rd, {5'h0, m_ones, 5'h0, m_cnt}, "count after freeze");
    chk_bit((t_res[1] - t_res[0]) inside {[1024 * BITC - 30 : 1024 * BITC + 30]}, 1'b1, "interval");
    stop_test();
  end
endmodule // test_sigma_delta_loop_decimator
bind sigma_delta_loop_decimator sd_loop_assertions #(.TICK_CYCLES(TICK_CYCLES)) chk (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .ce(ce), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .sample_data(sample_data), .sample_valid(sample_valid),
  .sample_req(sample_req), .gain_x8_en(gain_x8_en), .channel_sel(channel_sel), .port_a_out(port_a_out),
  .port_b_out(port_b_out));
`default_nettype wire
